// >>> logic/bit_shift_flag_execute_unit.sv
// bit-manipulation, shift, rotate and status-flag execution unit behind an apb slave
// Contract
// - i/o bit set forces one, two cycles
// - i/o bit clear forces zero, others kept
// - logical shifts fill zero, update Z,C,N,V
// - rotates go through carry, update Z,C,N,V
// - arithmetic right shift keeps top bit
// - nibble swap, flags untouched
// - status bit set/clear touches selected bit
// - bit store copies source bit to T
// - bit load copies T into bit
// - carry set and clear only
// - negative set and clear only
// - zero set and clear only
// - interrupt enable sets, disable clears I
// - signed flag set and clear only
// - overflow set and clear only
`timescale 1ns/1ps
`include "bit_unit_regs.svh"

module bit_shift_flag_execute_unit (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [7:0]  status_flags_register,
	output logic             busy
);

	bit_unit_pkg::state_t state_q;
	bit_unit_pkg::state_t state_d;
	logic                 prev_modify_q;
	logic                 prev_modify_d;

	logic [31:0] cmd_q;
	logic [31:0] cmd_d;
	logic [7:0]  operand_q;
	logic [7:0]  operand_d;
	logic [7:0]  result_q;
	logic [7:0]  result_d;
	logic [7:0]  flags_q;
	logic [7:0]  flags_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [2:0]  io_bit_q;
	logic [2:0]  io_bit_d;
	logic        io_set_q;
	logic        io_set_d;
	logic [`IO_AW-1:0] io_adr_q;
	logic [`IO_AW-1:0] io_adr_d;

	logic              setup;
	logic              access;
	logic              win_hit;
	logic              mapped;
	logic              io_wait;
	logic [`IO_AW-1:0] win_index;
	logic [`IO_AW-1:0] mem_rd_addr;
	logic [7:0]        mem_rd_data;
	logic              mem_wr_en;
	logic [`IO_AW-1:0] mem_wr_addr;
	logic [7:0]        mem_wr_data;

	bit_unit_pkg::op_t  cmd_op;
	logic [2:0]         cmd_bit;
	logic [`IO_AW-1:0]  cmd_adr;
	logic               cmd_go;

	assign setup     = psel && !penable;
	assign access    = psel && penable;
	assign win_hit   = paddr[7] == 1'b1;
	assign win_index = paddr[`IO_AW+1:2];
	assign mapped    = win_hit || paddr == `OFS_CMD || paddr == `OFS_OPERAND || paddr == `OFS_RESULT
		|| paddr == `OFS_FLAGS || paddr == `OFS_STATUS;

	// a window read right after a modify cycle would see the pre-write data, so it waits a cycle
	assign io_wait = win_hit && !pwrite && prev_modify_q;
	assign pready  = (state_q == bit_unit_pkg::st_idle) && !io_wait;
	assign pslverr = access && pready && !mapped;

	assign cmd_op  = bit_unit_pkg::op_t'(pwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
	assign cmd_bit = pwdata[`CMD_BIT_MSB:`CMD_BIT_LSB];
	assign cmd_adr = pwdata[`CMD_ADR_MSB:`CMD_ADR_LSB];
	assign cmd_go  = access && pready && pwrite && paddr == `OFS_CMD;

	assign prdata = (win_hit && !pwrite) ? {24'h000000, mem_rd_data} : prdata_q;
	assign status_flags_register = flags_q;
	assign busy   = state_q != bit_unit_pkg::st_idle;

	// the read port follows the bus address except on the edge that accepts a command write
	assign mem_rd_addr = cmd_go ? cmd_adr : win_index;

	io_space_mem u_io_space (
		.clk     (clk),
		.reset   (reset),
		.rd_addr (mem_rd_addr),
		.rd_data (mem_rd_data),
		.wr_en   (mem_wr_en),
		.wr_addr (mem_wr_addr),
		.wr_data (mem_wr_data)
	);

	// sequencing and i/o read-modify-write
	always_comb begin
		state_d       = state_q;
		prev_modify_d = state_q == bit_unit_pkg::st_io_modify;
		io_bit_d      = io_bit_q;
		io_set_d      = io_set_q;
		io_adr_d      = io_adr_q;
		mem_wr_en     = 1'b0;
		mem_wr_addr   = win_index;
		mem_wr_data   = pwdata[7:0];
		case (state_q)
			bit_unit_pkg::st_idle: begin
				if (cmd_go && (cmd_op == bit_unit_pkg::op_io_bit_set
					|| cmd_op == bit_unit_pkg::op_io_bit_clear)) begin
					state_d  = bit_unit_pkg::st_io_modify;
					io_bit_d = cmd_bit;
					io_adr_d = cmd_adr;
					io_set_d = cmd_op == bit_unit_pkg::op_io_bit_set;
				end else if (access && pwrite && win_hit) begin
					mem_wr_en = 1'b1;
				end
			end
			bit_unit_pkg::st_io_modify: begin
				mem_wr_en   = 1'b1;
				mem_wr_addr = io_adr_q;
				mem_wr_data = mem_rd_data;
				mem_wr_data[io_bit_q] = io_set_q;
				state_d     = bit_unit_pkg::st_idle;
			end
			default: begin
				state_d = bit_unit_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q       <= bit_unit_pkg::st_idle;
			prev_modify_q <= 1'b0;
			io_bit_q      <= 3'h0;
			io_set_q      <= 1'b0;
			io_adr_q      <= 5'h00;
		end else begin
			state_q       <= state_d;
			prev_modify_q <= prev_modify_d;
			io_bit_q      <= io_bit_d;
			io_set_q      <= io_set_d;
			io_adr_q      <= io_adr_d;
		end
	end

	// register file, datapath and flag updates
	always_comb begin
		logic [7:0] r;
		logic       c;
		r         = operand_q;
		c         = flags_q[`FLAG_C];
		cmd_d     = cmd_q;
		operand_d = operand_q;
		result_d  = result_q;
		flags_d   = flags_q;
		if (access && pready && pwrite) begin
			if (paddr == `OFS_OPERAND) begin
				operand_d = pwdata[7:0];
			end
			if (paddr == `OFS_FLAGS) begin
				flags_d = pwdata[7:0];
			end
		end
		if (cmd_go) begin
			cmd_d = pwdata;
			case (cmd_op)
				bit_unit_pkg::op_shift_left_logical: begin
					r = {operand_q[6:0], 1'b0};
					c = operand_q[7];
				end
				bit_unit_pkg::op_shift_right_logical: begin
					r = {1'b0, operand_q[7:1]};
					c = operand_q[0];
				end
				bit_unit_pkg::op_rotate_left_via_carry: begin
					r = {operand_q[6:0], flags_q[`FLAG_C]};
					c = operand_q[7];
				end
				bit_unit_pkg::op_rotate_right_via_carry: begin
					r = {flags_q[`FLAG_C], operand_q[7:1]};
					c = operand_q[0];
				end
				bit_unit_pkg::op_arithmetic_right_shift: begin
					r = {operand_q[7], operand_q[7:1]};
					c = operand_q[0];
				end
				bit_unit_pkg::op_nibble_swap: begin
					r = {operand_q[3:0], operand_q[7:4]};
				end
				bit_unit_pkg::op_transfer_flag_to_bit: begin
					r[cmd_bit] = flags_q[`FLAG_T];
				end
				default: begin
					r = operand_q;
				end
			endcase
			case (cmd_op)
				bit_unit_pkg::op_shift_left_logical,
				bit_unit_pkg::op_shift_right_logical,
				bit_unit_pkg::op_rotate_left_via_carry,
				bit_unit_pkg::op_rotate_right_via_carry,
				bit_unit_pkg::op_arithmetic_right_shift: begin
					// overflow after a shift is defined as N xor C
					result_d          = r;
					operand_d         = r;
					flags_d[`FLAG_C]  = c;
					flags_d[`FLAG_Z]  = r == 8'h00;
					flags_d[`FLAG_N]  = r[7];
					flags_d[`FLAG_V]  = r[7] ^ c;
				end
				bit_unit_pkg::op_nibble_swap,
				bit_unit_pkg::op_transfer_flag_to_bit: begin
					result_d  = r;
					operand_d = r;
				end
				// single-flag ops touch one bit; the rest pass through
				bit_unit_pkg::op_status_bit_set: begin
					flags_d[cmd_bit] = 1'b1;
				end
				bit_unit_pkg::op_status_bit_clear: begin
					flags_d[cmd_bit] = 1'b0;
				end
				bit_unit_pkg::op_bit_to_transfer_flag: begin
					flags_d[`FLAG_T] = operand_q[cmd_bit];
				end
				bit_unit_pkg::op_carry_set: begin
					flags_d[`FLAG_C] = 1'b1;
				end
				bit_unit_pkg::op_carry_clear: begin
					flags_d[`FLAG_C] = 1'b0;
				end
				bit_unit_pkg::op_negative_set: begin
					flags_d[`FLAG_N] = 1'b1;
				end
				bit_unit_pkg::op_negative_clear: begin
					flags_d[`FLAG_N] = 1'b0;
				end
				bit_unit_pkg::op_zero_set: begin
					flags_d[`FLAG_Z] = 1'b1;
				end
				bit_unit_pkg::op_zero_clear: begin
					flags_d[`FLAG_Z] = 1'b0;
				end
				bit_unit_pkg::op_interrupt_enable_set: begin
					flags_d[`FLAG_I] = 1'b1;
				end
				bit_unit_pkg::op_interrupt_enable_off: begin
					flags_d[`FLAG_I] = 1'b0;
				end
				bit_unit_pkg::op_signed_flag_set: begin
					flags_d[`FLAG_S] = 1'b1;
				end
				bit_unit_pkg::op_signed_flag_off: begin
					flags_d[`FLAG_S] = 1'b0;
				end
				bit_unit_pkg::op_overflow_set: begin
					flags_d[`FLAG_V] = 1'b1;
				end
				bit_unit_pkg::op_overflow_clear: begin
					flags_d[`FLAG_V] = 1'b0;
				end
				// unused codes and nop leave every flag alone
				default: begin
					flags_d = flags_d;
				end
			endcase
		end
	end

	// read data captured in the setup cycle so it is a flop by the access cycle
	always_comb begin
		prdata_d = prdata_q;
		if (setup) begin
			case (paddr)
				`OFS_CMD:     prdata_d = cmd_q;
				`OFS_OPERAND: prdata_d = {24'h000000, operand_q};
				`OFS_RESULT:  prdata_d = {24'h000000, result_q};
				`OFS_FLAGS:   prdata_d = {24'h000000, flags_q};
				`OFS_STATUS:  prdata_d = {31'h00000000, busy};
				default:      prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmd_q     <= `RST_CMD;
			operand_q <= `RST_OPERAND;
			result_q  <= `RST_RESULT;
			flags_q   <= `RST_FLAGS;
			prdata_q  <= 32'h0000_0000;
		end else begin
			cmd_q     <= cmd_d;
			operand_q <= operand_d;
			result_q  <= result_d;
			flags_q   <= flags_d;
			prdata_q  <= prdata_d;
		end
	end

endmodule

// >>> logic/bit_unit_regs.svh
// register offsets, field positions and reset values of the bit/shift/flag unit
`ifndef BIT_UNIT_REGS_SVH
`define BIT_UNIT_REGS_SVH

`define OFS_CMD      8'h00
`define OFS_OPERAND  8'h04
`define OFS_RESULT   8'h08
`define OFS_FLAGS    8'h0c
`define OFS_STATUS   8'h10
`define OFS_IO_BASE  8'h80

`define CMD_OP_LSB   0
`define CMD_OP_MSB   4
`define CMD_BIT_LSB  8
`define CMD_BIT_MSB  10
`define CMD_ADR_LSB  16
`define CMD_ADR_MSB  20

`define FLAG_C       0
`define FLAG_Z       1
`define FLAG_N       2
`define FLAG_V       3
`define FLAG_S       4
`define FLAG_H       5
`define FLAG_T       6
`define FLAG_I       7

`define STATUS_BUSY  0

`define RST_FLAGS    8'h00
`define RST_OPERAND  8'h00
`define RST_RESULT   8'h00
`define RST_CMD      32'h0000_0000

`define IO_WORDS     32
`define IO_AW        5
`define IO_OP_CYCLES 2

`endif

// >>> logic/bit_unit_pkg.sv
// types of the bit/shift/flag unit
package bit_unit_pkg;

	typedef enum logic [4:0] {
		op_nop                 = 5'h00,
		op_io_bit_set          = 5'h01,
		op_io_bit_clear        = 5'h02,
		op_shift_left_logical  = 5'h03,
		op_shift_right_logical = 5'h04,
		op_rotate_left_via_carry  = 5'h05,
		op_rotate_right_via_carry = 5'h06,
		op_arithmetic_right_shift = 5'h07,
		op_nibble_swap         = 5'h08,
		op_status_bit_set      = 5'h09,
		op_status_bit_clear    = 5'h0a,
		op_bit_to_transfer_flag   = 5'h0b,
		op_transfer_flag_to_bit   = 5'h0c,
		op_carry_set           = 5'h0d,
		op_carry_clear         = 5'h0e,
		op_negative_set        = 5'h0f,
		op_negative_clear      = 5'h10,
		op_zero_set            = 5'h11,
		op_zero_clear          = 5'h12,
		op_interrupt_enable_set   = 5'h13,
		op_interrupt_enable_off   = 5'h14,
		op_signed_flag_set     = 5'h15,
		op_signed_flag_off     = 5'h16,
		op_overflow_set        = 5'h17,
		op_overflow_clear      = 5'h18
	} op_t;

	typedef enum logic [0:0] {
		st_idle,
		st_io_modify
	} state_t;

endpackage

// >>> logic/io_space_mem.sv
// 32 x 8 i/o register space with registered read data
`timescale 1ns/1ps
`include "bit_unit_regs.svh"

module io_space_mem (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic [`IO_AW-1:0]   rd_addr,
	output logic      [7:0]          rd_data,
	input  wire logic                wr_en,
	input  wire logic [`IO_AW-1:0]   wr_addr,
	input  wire logic [7:0]          wr_data
);

	logic [7:0] mem_q [`IO_WORDS];
	logic [7:0] rd_data_q;

	// storage has no reset; only the read register does
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// read before write on a shared address: old value is returned
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= mem_q[rd_addr];
		end
	end

	assign rd_data = rd_data_q;

endmodule

// >>> bench/bit_unit_monitor.sv
// concurrent checks on the ports of the bit/shift/flag unit
`timescale 1ns/1ps
module bit_unit_monitor (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  status_flags_register,
	input wire logic        busy
);
	logic       go;
	logic [4:0] op;
	logic [7:0] fl;
	assign go = psel && penable && pready && pwrite && paddr == 8'h00;
	assign op = pwdata[4:0];
	assign fl = status_flags_register;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_io_set_busy: assert property (go && op == 5'h01 |=> busy ##1 !busy)
		else $error("io bit set did not take two cycles");
	a_io_clear_busy: assert property (go && op == 5'h02 |=> busy ##1 !busy)
		else $error("io bit clear did not take two cycles");
	a_swap_keeps_flags: assert property (go && op == 5'h08 |=> $stable(fl))
		else $error("nibble swap changed flags");
	a_status_bit_set: assert property (go && op == 5'h09 |=> fl == ($past(fl) | (8'h01 << $past(pwdata[10:8]))))
		else $error("status bit set wrong");
	a_carry_set_only: assert property (go && op == 5'h0d |=> fl == ($past(fl) | 8'h01))
		else $error("carry set wrong");
	a_negative_clear_only: assert property (go && op == 5'h10 |=> fl == ($past(fl) & 8'hfb))
		else $error("negative clear wrong");
	a_zero_clear_only: assert property (go && op == 5'h12 |=> fl == ($past(fl) & 8'hfd))
		else $error("zero clear wrong");
	a_interrupt_off: assert property (go && op == 5'h14 |=> fl == ($past(fl) & 8'h7f))
		else $error("interrupt disable wrong");
	a_signed_set_only: assert property (go && op == 5'h15 |=> fl == ($past(fl) | 8'h10))
		else $error("signed flag set wrong");
	a_overflow_clear_only: assert property (go && op == 5'h18 |=> fl == ($past(fl) & 8'hf7))
		else $error("overflow clear wrong");
endmodule
bind bit_shift_flag_execute_unit bit_unit_monitor u_bit_unit_monitor (.clk(clk), .reset(reset), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .status_flags_register(status_flags_register), .busy(busy));

// >>> bench/apb_host_model.sv
// apb requester standing in for the core's decode and register-file side
`timescale 1ns/1ps
module apb_host_model (
	input  wire logic        clk,
	output logic      [7:0]  paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		paddr <= 8'h00;
		psel <= 1'h0;
		penable <= 1'h0;
		pwrite <= 1'h0;
		pwdata <= 32'h0;
	end
	// ends with an idle edge so no strobe is driven twice in one time step
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		pwdata <= ~d;
		@(posedge clk);
	endtask
endmodule

// >>> bench/tb_top.sv
// self-checking bench of the bit/shift/flag unit
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        reset;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  f;
	logic [7:0]  r;
	logic [7:0]  d;
	logic [31:0] q;
	logic        e;
	logic [7:0]  flags_w;
	logic        busy_w;
	int          n_busy = 0;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cycles = 0;
	localparam int fpos [6] = '{0, 2, 1, 7, 4, 3};
	localparam logic [7:0] dv [3] = '{8'h40, 8'h81, 8'h01};
	bit_shift_flag_execute_unit u_bit_shift_flag_execute_unit (.clk(clk), .reset(reset), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .status_flags_register(flags_w), .busy(busy_w));
	apb_host_model u_apb_host_model (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task automatic give_verdict;
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		u_apb_host_model.xfer(a, 1'h1, v, q, e);
	endtask
	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		u_apb_host_model.xfer(a, 1'h0, 32'h0, q, e);
		chk(name, exp, q);
	endtask
	task automatic cmd(input logic [4:0] op, input logic [2:0] b, input logic [4:0] adr);
		wr(8'h00, {11'h0, adr, 5'h0, b, 3'h0, op});
	endtask
	// reference shift model; nibble swap leaves flags alone
	function automatic logic [15:0] shf(input logic [4:0] op, input logic [7:0] v, input logic [7:0] fl);
		logic [7:0] res;
		logic       c;
		case (op)
			5'h03: {c, res} = {v, 1'h0};
			5'h04: {res, c} = {1'h0, v};
			5'h05: {c, res} = {v, fl[0]};
			5'h06: {res, c} = {fl[0], v};
			5'h07: {res, c} = {v[7], v};
			default: return {v[3:0], v[7:4], fl};
		endcase
		fl[0] = c;
		fl[1] = res == 8'h00;
		fl[2] = res[7];
		fl[3] = res[7] ^ c;
		return {res, fl};
	endfunction
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// busy is counted mid-cycle, where it has settled
	always @(negedge clk)
		if (busy_w === 1'h1)
			n_busy <= n_busy + 1;
	// ceiling well above the roughly 900 cycles the sequence needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_errors++;
			give_verdict;
		end
	end
	initial begin
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		rd("flags_reset", 8'h0c, 32'h0);
		f = 8'h5a;
		wr(8'h0c, {24'h0, f});
		// codes past the last flag op must leave every flag alone
		for (int k = 0; k < 16; k++) begin
			if (k < 12)
				f[fpos[k/2]] = ~k[0];
			cmd(5'h0d + k[4:0], 3'h0, 5'h0);
			rd("flag_op", 8'h0c, {24'h0, f});
			chk("flags_port", {24'h0, f}, {24'h0, flags_w});
		end
		for (int b = 0; b < 8; b++) begin
			f[b] = 1'h1;
			cmd(5'h09, b[2:0], 5'h0);
			rd("status_set", 8'h0c, {24'h0, f});
			f[7-b] = 1'h0;
			cmd(5'h0a, 3'h7 - b[2:0], 5'h0);
			rd("status_clear", 8'h0c, {24'h0, f});
		end
		for (int v = 0; v < 3; v++)
			for (int c = 0; c < 2; c++)
				for (int op = 3; op < 9; op++) begin
					d = dv[v];
					f[0] = c[0];
					wr(8'h0c, {24'h0, f});
					wr(8'h04, {24'h0, d});
					cmd(op[4:0], 3'h0, 5'h0);
					{r, f} = shf(op[4:0], d, f);
					rd("shift_result", 8'h08, {24'h0, r});
					rd("shift_flags", 8'h0c, {24'h0, f});
				end
		d = 8'h96;
		for (int b = 0; b < 8; b++) begin
			wr(8'h04, {24'h0, d});
			cmd(5'h0b, b[2:0], 5'h0);
			f[6] = d[b];
			rd("bit_store", 8'h0c, {24'h0, f});
			wr(8'h04, 32'h0);
			cmd(5'h0c, b[2:0], 5'h0);
			rd("bit_load", 8'h04, {24'h0, 8'h00 | (f[6] << b)});
			rd("bit_load_flags", 8'h0c, {24'h0, f});
		end
		wr(8'h8c, 32'h5a);
		cmd(5'h01, 3'h0, 5'h03);
		rd("io_set", 8'h8c, 32'h5b);
		cmd(5'h02, 3'h6, 5'h03);
		rd("io_clear", 8'h8c, 32'h1b);
		cmd(5'h01, 3'h7, 5'h03);
		rd("io_set_top", 8'h8c, 32'h9b);
		rd("cmd_readback", 8'h00, 32'h0003_0701);
		chk("mapped_err", 32'h0, {31'h0, e});
		rd("status_idle", 8'h10, 32'h0);
		chk("busy_cycles", 32'h3, n_busy);
		chk("busy_port", 32'h0, {31'h0, busy_w});
		u_apb_host_model.xfer(8'h40, 1'h0, 32'h0, q, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
		give_verdict;
	end
endmodule
